// File: common/amp_ctrl_defines.svh
// Purpose: Offsets, field positions and reset values of the analog control bank
// Assumes: 8-bit registers on the serial control bus register port
// Notes:   Included by the design modules and the host model
`ifndef AMP_CTRL_DEFINES_SVH
`define AMP_CTRL_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define OUT_STAGE_CTRL_ADDR   8'h06
`define ANALOG_CTRL_TWO_ADDR  8'h14

// ------------------------------------------------------------
// Analog control two fields
// ------------------------------------------------------------
`define ACT_RSVD_HI_MSB       7
`define ACT_RSVD_HI_LSB       4
`define ACT_PULLUP_BIT        3
`define ACT_REG_LVL_BIT       2
`define ACT_RSVD_LO_BIT       1
`define ACT_CUR_TRIM_BIT      0
`define ACT_RESET             8'h02
`define ACT_RSVD_HI_VAL       4'h0
`define ACT_RSVD_LO_VAL       1'h1

// ------------------------------------------------------------
// Output stage control fields
// ------------------------------------------------------------
`define OSC_RATE_MSB          6
`define OSC_RATE_LSB          4
`define OSC_GAIN_MSB          3
`define OSC_GAIN_LSB          2
`define OSC_RATE_RESET        3'h5
`define OSC_GAIN_RESET        2'h1
`define OSC_RESET             8'h54

// ------------------------------------------------------------
// Reset values of controls, flag and read data
// ------------------------------------------------------------
`define ACT_PULLUP_RESET      1'b0
`define ACT_REG_LVL_RESET     1'b0
`define ACT_CUR_TRIM_RESET    1'b0
`define ERR_RESET             1'b0
`define RDATA_RESET           8'h00
`define RDATA_UNMAPPED        8'h00

`endif

// File: common/amp_ctrl_pkg.sv
// Purpose: Shared types of the analog control bank
// Assumes: Defines header is on the include path
// Notes:   Holds types only; numbers live in the defines header
package amp_ctrl_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [7:0] reg_addr_t;
endpackage : amp_ctrl_pkg

// File: hw/ctrl_reg8.sv
// Purpose: One 8-bit read-write control register with reset value
// Assumes: Synchronous active-high reset, write strobe on clk
// Notes:   Reads back what was last written, reserved bits included
`timescale 1ns/1ps
`include "amp_ctrl_defines.svh"

module ctrl_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic                    clk,     // System clock
	input  wire logic                    sys_rst, // Sync reset
	input  wire logic                    wr_en,   // Write strobe
	input  wire amp_ctrl_pkg::reg_byte_t wr_data, // Write data
	output      amp_ctrl_pkg::reg_byte_t value_q  // Stored value
);
	import amp_ctrl_pkg::*;

	// Storage; reserved bits are kept verbatim so reads echo writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			value_q <= RESET_VAL;
		end else if (wr_en) begin
			value_q <= wr_data;
		end
	end
endmodule : ctrl_reg8

// File: hw/amp_analog_control_regs.sv
// Purpose: Analog control register bank of a mono class-D amplifier
// Assumes: Serial bus decoder delivers byte writes and reads on clk
// Notes:   Summary of operation is listed below
//          Control outputs follow a taken write by two clock edges
//          Reserved bits are stored as written and flagged, never forced
//
// Summary of operation
// - Bits 7-4 of analog control two are reserved, reset to zero and written as zeros by the host.
// - Bit 3 of analog control two enables the fault pin pull-up when set, disabled at reset.
// - Bit 2 selects the regulator level, normal at reset and reduced for low supply when set.
// - Bit 1 of analog control two is reserved, resets to one and is written as one by the host.
// - Bit 0 when set lowers static analog current, not reduced at reset.
// - Bits 6-4 of output control at 0x06 hold the switching rate, reset to 101.
// - Bits 3-2 of output control hold the analog gain, reset to the middle gain.
`timescale 1ns/1ps
`include "amp_ctrl_defines.svh"

module amp_analog_control_regs (
	input  wire logic                    clk,                 // 40 MHz system clock
	input  wire logic                    sys_rst,             // Sync reset, active high
	input  wire logic                    reg_wr,              // Register write strobe
	input  wire logic                    reg_rd,              // Register read strobe
	input  wire amp_ctrl_pkg::reg_addr_t reg_addr,            // Register offset
	input  wire amp_ctrl_pkg::reg_byte_t reg_wdata,           // Write data
	output      amp_ctrl_pkg::reg_byte_t reg_rdata_q,         // Read data
	output      logic                    rsvd_write_err_q,    // Host broke reserved bit values
	output      logic                    fault_pin_pullup_en, // Fault pin pull-up enable
	output      logic                    regulator_level_sel, // Reduced regulator level
	output      logic                    analog_current_trim, // Reduce analog static current
	output      logic [2:0]              pwm_rate_sel,        // Switching rate field
	output      logic [1:0]              analog_gain_sel      // Analog gain field
);
	import amp_ctrl_pkg::*;

	reg_byte_t act_q;
	reg_byte_t osc_q;
	logic      act_wr;
	logic      osc_wr;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	assign act_wr = reg_wr && (reg_addr == `ANALOG_CTRL_TWO_ADDR);
	assign osc_wr = reg_wr && (reg_addr == `OUT_STAGE_CTRL_ADDR);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	ctrl_reg8 #(.RESET_VAL(`ACT_RESET)) u_act (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (act_wr),
		.wr_data (reg_wdata),
		.value_q (act_q)
	);

	ctrl_reg8 #(.RESET_VAL(`OSC_RESET)) u_osc (
		.clk     (clk),
		.sys_rst (sys_rst),
		.wr_en   (osc_wr),
		.wr_data (reg_wdata),
		.value_q (osc_q)
	);

	// ------------------------------------------------------------
	// Analog controls, registered so every output is a flip-flop
	// ------------------------------------------------------------
	// Fault pin pull-up enable, one cycle behind the stored byte
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fault_pin_pullup_en <= `ACT_PULLUP_RESET;
		end else begin
			fault_pin_pullup_en <= act_q[`ACT_PULLUP_BIT];
		end
	end

	// Regulator level; the reduced level is only safe on a low output stage supply
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			regulator_level_sel <= `ACT_REG_LVL_RESET;
		end else begin
			regulator_level_sel <= act_q[`ACT_REG_LVL_BIT];
		end
	end

	// Static current trim of the analog domain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			analog_current_trim <= `ACT_CUR_TRIM_RESET;
		end else begin
			analog_current_trim <= act_q[`ACT_CUR_TRIM_BIT];
		end
	end

	// Switching rate; the extra stage costs a cycle but keeps the pins glitch free
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pwm_rate_sel <= `OSC_RATE_RESET;
		end else begin
			pwm_rate_sel <= osc_q[`OSC_RATE_MSB:`OSC_RATE_LSB];
		end
	end

	// Analog gain field
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			analog_gain_sel <= `OSC_GAIN_RESET;
		end else begin
			analog_gain_sel <= osc_q[`OSC_GAIN_MSB:`OSC_GAIN_LSB];
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	// Read data; unmapped offsets read zero, a same-cycle write is not seen yet
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata_q <= `RDATA_RESET;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ANALOG_CTRL_TWO_ADDR: reg_rdata_q <= act_q;
				`OUT_STAGE_CTRL_ADDR:  reg_rdata_q <= osc_q;
				default:               reg_rdata_q <= `RDATA_UNMAPPED;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Reserved value check
	// ------------------------------------------------------------
	// Sticky flag: host wrote reserved bits wrongly; cleared only by reset
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rsvd_write_err_q <= `ERR_RESET;
		end else if (act_wr && ((reg_wdata[`ACT_RSVD_HI_MSB:`ACT_RSVD_HI_LSB] != `ACT_RSVD_HI_VAL) ||
			(reg_wdata[`ACT_RSVD_LO_BIT] != `ACT_RSVD_LO_VAL))) begin
			rsvd_write_err_q <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Assertions: read back and storage
	// ------------------------------------------------------------
	act_readback_a: assert property (@(posedge clk) disable iff (sys_rst)
		act_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == `ANALOG_CTRL_TWO_ADDR && !reg_wr)
		|=> reg_rdata_q == $past(reg_wdata, 3))
		else $error("analog control readback mismatch");
	osc_readback_a: assert property (@(posedge clk) disable iff (sys_rst)
		osc_wr ##1 !reg_wr ##1 (reg_rd && reg_addr == `OUT_STAGE_CTRL_ADDR && !reg_wr)
		|=> reg_rdata_q == $past(reg_wdata, 3))
		else $error("output control readback mismatch");
	unmapped_rd_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_rd && reg_addr != `ANALOG_CTRL_TWO_ADDR && reg_addr != `OUT_STAGE_CTRL_ADDR)
		|=> reg_rdata_q == `RDATA_UNMAPPED)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data changed without a read");
	stray_write_a: assert property (@(posedge clk) disable iff (sys_rst)
		(reg_wr && reg_addr != `ANALOG_CTRL_TWO_ADDR && reg_addr != `OUT_STAGE_CTRL_ADDR)
		|=> $stable(act_q) && $stable(osc_q))
		else $error("unmapped write changed a register");
	act_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!act_wr |=> $stable(act_q))
		else $error("analog control changed without a write");
	osc_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
		!osc_wr |=> $stable(osc_q))
		else $error("output control changed without a write");

	// ------------------------------------------------------------
	// Assertions: analog controls
	// ------------------------------------------------------------
	pullup_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
		act_wr |=> ##1 fault_pin_pullup_en == $past(reg_wdata[`ACT_PULLUP_BIT], 2))
		else $error("pull-up enable wrong");
	reg_level_a: assert property (@(posedge clk) disable iff (sys_rst)
		act_wr |=> ##1 regulator_level_sel == $past(reg_wdata[`ACT_REG_LVL_BIT], 2))
		else $error("regulator level wrong");
	cur_trim_a: assert property (@(posedge clk) disable iff (sys_rst)
		act_wr |=> ##1 analog_current_trim == $past(reg_wdata[`ACT_CUR_TRIM_BIT], 2))
		else $error("current trim wrong");
	rate_field_a: assert property (@(posedge clk) disable iff (sys_rst)
		osc_wr |=> ##1 pwm_rate_sel == $past(reg_wdata[`OSC_RATE_MSB:`OSC_RATE_LSB], 2))
		else $error("switching rate wrong");
	gain_field_a: assert property (@(posedge clk) disable iff (sys_rst)
		osc_wr |=> ##1 analog_gain_sel == $past(reg_wdata[`OSC_GAIN_MSB:`OSC_GAIN_LSB], 2))
		else $error("analog gain wrong");
	rate_reset_a: assert property (@(posedge clk)
		sys_rst |=> pwm_rate_sel == `OSC_RATE_RESET && analog_gain_sel == `OSC_GAIN_RESET)
		else $error("output control reset value wrong");
	level_reset_a: assert property (@(posedge clk)
		sys_rst |=> !regulator_level_sel)
		else $error("regulator level reset value wrong");

	// ------------------------------------------------------------
	// Assertions: reserved bits
	// ------------------------------------------------------------
	act_reset_a: assert property (@(posedge clk)
		sys_rst |=> act_q == `ACT_RESET && !fault_pin_pullup_en && !analog_current_trim)
		else $error("analog control reset value wrong");
	rsvd_err_a: assert property (@(posedge clk) disable iff (sys_rst)
		(act_wr && reg_wdata[`ACT_RSVD_LO_BIT] != `ACT_RSVD_LO_VAL) |=> rsvd_write_err_q)
		else $error("reserved write not flagged");
	rsvd_hi_err_a: assert property (@(posedge clk) disable iff (sys_rst)
		(act_wr && reg_wdata[`ACT_RSVD_HI_MSB:`ACT_RSVD_HI_LSB] != `ACT_RSVD_HI_VAL) |=> rsvd_write_err_q)
		else $error("reserved high bits write not flagged");
	err_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
		rsvd_write_err_q |=> rsvd_write_err_q)
		else $error("reserved write flag cleared without reset");

	// ------------------------------------------------------------
	// Cover points
	// ------------------------------------------------------------
	act_write_c:    cover property (@(posedge clk) disable iff (sys_rst) act_wr ##2 fault_pin_pullup_en);
	osc_write_c:    cover property (@(posedge clk) disable iff (sys_rst) osc_wr ##2 reg_rd);
	rsvd_err_c:     cover property (@(posedge clk) disable iff (sys_rst) $rose(rsvd_write_err_q));
	act_readback_c: cover property (@(posedge clk) disable iff (sys_rst)
		act_wr ##2 (reg_rd && reg_addr == `ANALOG_CTRL_TWO_ADDR));
	unmapped_rd_c:  cover property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr != `ANALOG_CTRL_TWO_ADDR && reg_addr != `OUT_STAGE_CTRL_ADDR);
endmodule : amp_analog_control_regs

// File: verif/amp_host_model.sv
// Purpose: Host model driving the register port of the analog bank
// Assumes: Requests launched just after a rising edge, held one edge
// Notes:   Address and write data inverted after release so stale values never match
`timescale 1ns/1ps
`include "amp_ctrl_defines.svh"
module amp_host_model (
	input  wire logic                    clk,         // System clock
	input  wire amp_ctrl_pkg::reg_byte_t reg_rdata_q, // Read data
	output      logic                    reg_wr,      // Write strobe
	output      logic                    reg_rd,      // Read strobe
	output      amp_ctrl_pkg::reg_addr_t reg_addr,    // Register offset
	output      amp_ctrl_pkg::reg_byte_t reg_wdata    // Write data
);
	import amp_ctrl_pkg::*;
	// ------------------------------------------------------------
	// Bus cycles
	// ------------------------------------------------------------
	// Idle bus at time zero
	initial begin
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 8'h00;
		reg_wdata = 8'h00;
	end
	// Raw write, also used to break reserved values on purpose
	task automatic wr(input reg_addr_t a, input reg_byte_t d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr
	// Legal write to analog control two, reserved bits forced
	task automatic wr_act(input reg_byte_t d);
		wr(`ANALOG_CTRL_TWO_ADDR, {`ACT_RSVD_HI_VAL, d[3:2], `ACT_RSVD_LO_VAL, d[0]});
	endtask : wr_act
	// Read; data taken once the taking edge has landed
	task automatic rd(input reg_addr_t a, output reg_byte_t d);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata_q;
	endtask : rd
endmodule : amp_host_model

// File: verif/tb_amp_analog_control_regs.sv
// Purpose: Self-checking bench of the analog control bank
// Assumes: Host model owns the register port
// Notes:   Control bus packs err, pull-up, level, trim, rate, gain
`timescale 1ns/1ps
module tb_amp_analog_control_regs;
	import amp_ctrl_pkg::*;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] r; logic [8:0] c;} row_t;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reg_wr, reg_rd, rsvd_write_err_q, fault_pin_pullup_en, regulator_level_sel, analog_current_trim;
	reg_addr_t reg_addr;
	reg_byte_t reg_wdata, reg_rdata_q, rb;
	logic [2:0] pwm_rate_sel;
	logic [1:0] analog_gain_sel;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	wire logic [8:0] ctl = {rsvd_write_err_q, fault_pin_pullup_en, regulator_level_sel, analog_current_trim,
		pwm_rate_sel, analog_gain_sel};
	// Legal rows, unmapped offset last: must be ignored and read as zero
	row_t rows [7] = '{'{8'h14, 8'h0A, 8'h0A, 9'h095}, '{8'h14, 8'h06, 8'h06, 9'h055},
		'{8'h14, 8'h03, 8'h03, 9'h035}, '{8'h06, 8'h00, 8'h00, 9'h020}, '{8'h06, 8'h7C, 8'h7C, 9'h03F},
		'{8'h14, 8'h0E, 8'h0E, 9'h0DF}, '{8'h20, 8'hFF, 8'h00, 9'h0DF}};
	always #12.5 clk = ~clk;
	amp_analog_control_regs u_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
		.rsvd_write_err_q(rsvd_write_err_q), .fault_pin_pullup_en(fault_pin_pullup_en),
		.regulator_level_sel(regulator_level_sel), .analog_current_trim(analog_current_trim),
		.pwm_rate_sel(pwm_rate_sel), .analog_gain_sel(analog_gain_sel));
	amp_host_model u_host (.clk(clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata));
	// ------------------------------------------------------------
	// Compare and closing
	// ------------------------------------------------------------
	task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk_byte
	task automatic chk_ctl(input string n, input logic [8:0] e);
		n_checks++;
		if (ctl !== e) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, e, ctl);
		end
	endtask : chk_ctl
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	// Hang guard, far above the roughly 60 cycles needed
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_fail++;
			end_sim();
		end
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk_ctl("ctl reset", 9'h015);
		u_host.rd(8'h14, rb);
		chk_byte("act reset", 8'h02, rb);
		u_host.rd(8'h06, rb);
		chk_byte("osc reset", 8'h54, rb);
		$display("test reset done");
		// Each row: write, read back, then control outputs
		foreach (rows[i]) begin
			u_host.wr(rows[i].a, rows[i].d);
			u_host.rd(rows[i].a, rb);
			chk_byte("row read", rows[i].r, rb);
			chk_ctl("row ctl", rows[i].c);
		end
		$display("test table done");
		u_host.wr_act(8'hF9);
		u_host.rd(8'h14, rb);
		chk_byte("act legal", 8'h0B, rb);
		chk_ctl("ctl legal", 9'h0BF);
		// Reserved bits broken: stored as written and flagged
		u_host.wr(8'h14, 8'hF0);
		u_host.rd(8'h14, rb);
		chk_byte("act rsvd", 8'hF0, rb);
		chk_ctl("err set", 9'h11F);
		$display("test reserved done");
		// Second reset in mid-run restores every field
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		#1;
		chk_ctl("ctl rereset", 9'h015);
		u_host.rd(8'h14, rb);
		chk_byte("act rereset", 8'h02, rb);
		$display("test rereset done");
		end_sim();
	end
endmodule : tb_amp_analog_control_regs
